/* File: include/uevf_pkg.sv */
// Constants shared by the USB device event-flag block.
package uevf_pkg;

	// Register byte offsets on the bus
	localparam logic [7:0] OFS_STATUS = 8'h00;
	localparam logic [7:0] OFS_ENABLE = 8'h04;
	localparam logic [7:0] OFS_CLEAR = 8'h08;
	localparam logic [7:0] OFS_SET = 8'h0c;

	// Flag field positions
	localparam int NFLAG = 14;
	localparam int BIT_FRAME = 0;
	localparam int BIT_EP0 = 1;
	localparam int BIT_BUS = 9;
	localparam int BIT_CMD = 10;
	localparam int BIT_REPLY = 11;
	localparam int BIT_RXD = 12;
	localparam int BIT_TXF = 13;

	// Values after reset
	localparam logic [13:0] STATUS_RST = 14'h0400;
	localparam logic [13:0] ENABLE_RST = 14'h0000;
	localparam logic [31:0] DATA_RST = 32'h0000_0000;

	// Frame tick timing
	localparam int unsigned FRAME_PERIOD_NS = 1000000;
	localparam int unsigned CLK_PERIOD_NS = 10;
	localparam int unsigned FRAME_CYCLES = FRAME_PERIOD_NS / CLK_PERIOD_NS;
	localparam int FRAME_W = 17;

	// Byte counter width of the engine's packet counts
	localparam int CNT_W = 10;

endpackage : uevf_pkg

/* File: include/uevf_flag_if.sv */
// Carrier between the bus front end and the flag store.
interface uevf_flag_if;

	// Hardware event pulses, one bit per flag
	logic [13:0] hw_set;
	// Set-port write mask
	logic [13:0] sw_set;
	// Clear-port write mask
	logic [13:0] sw_clr;
	// Current pending flags
	logic [13:0] flags;

	// Front end drives requests and reads flags
	modport ctrl (
		output hw_set,
		output sw_set,
		output sw_clr,
		input flags
	);

	// Store takes requests and shows flags
	modport store (
		input hw_set,
		input sw_set,
		input sw_clr,
		output flags
	);

endinterface : uevf_flag_if

/* File: src/uevf_flags.sv */
// Sticky event flag store, one flop per status bit.
module uevf_flags (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Flag requests and state
	uevf_flag_if.store fl
);

	// Registered flags
	logic [13:0] flags_ff;
	// Next flag values
	logic [13:0] nxt_flags;

	// Each bit is its own sticky cell; only reset values differ
	genvar i;
	generate
		for (i = 0; i < uevf_pkg::NFLAG; i++) begin : g_flag
			// Set wins over clear, so an event never slips away
			always_comb begin
				nxt_flags[i] = fl.flags[i];
				if (fl.sw_clr[i]) begin
					nxt_flags[i] = 1'b0;
				end
				if (fl.sw_set[i] || fl.hw_set[i]) begin
					nxt_flags[i] = 1'b1;
				end
			end

			// Register the cell
			always_ff @(posedge clk_i) begin
				if (rst_i) begin
					flags_ff[i] <= uevf_pkg::STATUS_RST[i];
				end else begin
					flags_ff[i] <= nxt_flags[i];
				end
			end
		end
	endgenerate

	// Flags leave straight from the flops
	assign fl.flags = flags_ff;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	// Hardware event always lands, clear or not
	set_wins_a: assert property ((fl.hw_set & fl.sw_clr) != 14'h0 |=>
		((flags_ff & $past(fl.hw_set)) == $past(fl.hw_set)))
		else $error("event lost against clear");

	// Clear-only bits drop, others untouched
	clear_only_a: assert property (
		(fl.sw_set | fl.hw_set) == 14'h0 |=>
		flags_ff == ($past(flags_ff) & ~$past(fl.sw_clr)))
		else $error("clear port misbehaves");

	// Set port raises written bits
	set_port_a: assert property (fl.sw_set != 14'h0 |=>
		((flags_ff & $past(fl.sw_set)) == $past(fl.sw_set)))
		else $error("set port misbehaves");

	// Flags hold without any request
	hold_flags_a: assert property (
		(fl.sw_set | fl.hw_set | fl.sw_clr) == 14'h0 |=> $stable(flags_ff))
		else $error("flag changed without cause");

	// A flag cleared after being set
	clear_seen_c: cover property (flags_ff[1] ##1 !flags_ff[1]);

endmodule : uevf_flags

/* File: src/uevf_top.sv */
// USB device event flags: Wishbone slave, event capture, interrupt.
module uevf_top #(
	// Frame tick period in clock cycles, shorten for simulation
	parameter int unsigned FRAME_CYCLES = uevf_pkg::FRAME_CYCLES
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Wishbone classic slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// Endpoint event pulses, bit n for physical endpoint n
	input wire logic [7:0] ep_event_i,
	// Bus state change pulses
	input wire logic bus_reset_i,
	input wire logic suspend_chg_i,
	input wire logic connect_chg_i,
	// Command engine pulses
	input wire logic cmd_done_i,
	input wire logic reply_ready_i,
	// Packet byte counts from the engine
	input wire logic [9:0] rx_remaining_i,
	input wire logic [9:0] tx_written_i,
	input wire logic [9:0] transmit_length_i,
	// Interrupt to the processor
	output logic irq_o
);

	// Carrier to the flag store
	uevf_flag_if fl ();

	// Flag store instance
	uevf_flags u_flags (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.fl(fl.store)
	);

	// ------------------------------------------------------------
	// Bus front end
	// ------------------------------------------------------------

	// Acknowledge flop
	logic ack_ff;
	logic nxt_ack;
	// Read data flop
	logic [31:0] rdata_ff;
	logic [31:0] nxt_rdata;
	// Enable mask register
	logic [13:0] enable_ff;
	logic [13:0] nxt_enable;
	// Request present on the bus
	logic req;
	// Write lands at the edge where the master sees ack
	logic wr_go;
	// Byte lane mask built from sel
	logic [31:0] lane_mask;
	// Masked write data
	logic [31:0] wdata_m;

	// Request qualifiers
	assign req = wb_cyc_i && wb_stb_i;
	assign wr_go = req && ack_ff && wb_we_i;

	// Byte lanes expand to a bit mask
	always_comb begin
		lane_mask = 32'h0;
		for (int b = 0; b < 4; b++) begin
			lane_mask[b*8 +: 8] = {8{wb_sel_i[b]}};
		end
		wdata_m = wb_dat_i & lane_mask;
	end

	// Ack rises one cycle after the request and drops after one cycle,
	// so back-to-back requests each see a fresh handshake
	always_comb begin
		nxt_ack = req && !ack_ff;
	end

	// Local copy of the data reset value, also the idle read data
	localparam logic [31:0] DATA_RST_C = uevf_pkg::DATA_RST;

	// Read data is captured with the ack so it is stable while ack is high
	always_comb begin
		nxt_rdata = DATA_RST_C;
		if (req && !ack_ff && !wb_we_i) begin
			if (wb_adr_i == uevf_pkg::OFS_STATUS) begin
				// Reserved bits read zero
				nxt_rdata = {18'h0, fl.flags};
			end else if (wb_adr_i == uevf_pkg::OFS_ENABLE) begin
				nxt_rdata = {18'h0, enable_ff};
			end else if (wb_adr_i == uevf_pkg::OFS_CLEAR) begin
				nxt_rdata = DATA_RST_C;
			end else if (wb_adr_i == uevf_pkg::OFS_SET) begin
				nxt_rdata = DATA_RST_C;
			end else begin
				// Unmapped offsets answer with zero
				nxt_rdata = DATA_RST_C;
			end
		end
	end

	// Enable mask: byte-lane merge, reserved bits never stored
	always_comb begin
		nxt_enable = enable_ff;
		if (wr_go && wb_adr_i == uevf_pkg::OFS_ENABLE) begin
			nxt_enable = (enable_ff & ~lane_mask[13:0]) | wdata_m[13:0];
		end
	end

	// Clear and set ports; a status write reaches neither
	always_comb begin
		fl.sw_clr = 14'h0;
		fl.sw_set = 14'h0;
		if (wr_go && wb_adr_i == uevf_pkg::OFS_CLEAR) begin
			fl.sw_clr = wdata_m[13:0];
		end else if (wr_go && wb_adr_i == uevf_pkg::OFS_SET) begin
			fl.sw_set = wdata_m[13:0];
		end
		// Writes to offset zero fall through untouched
	end

	// Bus registers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_ff <= 1'b0;
			rdata_ff <= uevf_pkg::DATA_RST;
			enable_ff <= uevf_pkg::ENABLE_RST;
		end else begin
			ack_ff <= nxt_ack;
			rdata_ff <= nxt_rdata;
			enable_ff <= nxt_enable;
		end
	end

	// Bus outputs come from flops
	assign wb_ack_o = ack_ff;
	assign wb_dat_o = rdata_ff;

	// ------------------------------------------------------------
	// Event capture
	// ------------------------------------------------------------

	// Frame period counter
	logic [16:0] frame_cnt_ff;
	logic [16:0] nxt_frame_cnt;
	// Last seen receive remaining count
	logic [9:0] rx_prev_ff;
	logic [9:0] nxt_rx_prev;
	// Transmit count matched length last cycle
	logic tx_eq_ff;
	logic nxt_tx_eq;
	// Combinational event terms
	logic frame_tick;
	logic tx_eq;
	// Last count of the frame period
	localparam logic [16:0] FRAME_LAST = 17'(FRAME_CYCLES - 1);

	// Frame counter wraps once per millisecond
	always_comb begin
		frame_tick = (frame_cnt_ff == FRAME_LAST);
		if (frame_tick) begin
			nxt_frame_cnt = 17'h0;
		end else begin
			nxt_frame_cnt = frame_cnt_ff + 17'h1;
		end
	end

	// Transmit fill only counts once per match; a length of zero never
	// matches, so an idle engine cannot keep raising the flag
	always_comb begin
		tx_eq = (tx_written_i == transmit_length_i) &&
			(transmit_length_i != 10'h0);
		nxt_tx_eq = tx_eq;
		nxt_rx_prev = rx_remaining_i;
	end

	// Gather every source into the flag layout
	always_comb begin
		fl.hw_set = 14'h0;
		fl.hw_set[uevf_pkg::BIT_FRAME] = frame_tick;
		fl.hw_set[uevf_pkg::BIT_EP0 +: 8] = ep_event_i;
		fl.hw_set[uevf_pkg::BIT_BUS] =
			bus_reset_i || suspend_chg_i || connect_chg_i;
		fl.hw_set[uevf_pkg::BIT_CMD] = cmd_done_i;
		fl.hw_set[uevf_pkg::BIT_REPLY] = reply_ready_i;
		// Drained when the count steps down onto zero
		fl.hw_set[uevf_pkg::BIT_RXD] =
			(rx_prev_ff != 10'h0) && (rx_remaining_i == 10'h0);
		fl.hw_set[uevf_pkg::BIT_TXF] = tx_eq && !tx_eq_ff;
	end

	// Event tracking registers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			frame_cnt_ff <= 17'h0;
			rx_prev_ff <= 10'h0;
			tx_eq_ff <= 1'b0;
		end else begin
			frame_cnt_ff <= nxt_frame_cnt;
			rx_prev_ff <= nxt_rx_prev;
			tx_eq_ff <= nxt_tx_eq;
		end
	end

	// ------------------------------------------------------------
	// Interrupt line
	// ------------------------------------------------------------

	// Registered interrupt
	logic irq_ff;
	logic nxt_irq;

	// Only enabled flags reach the line; masked ones stay pending
	always_comb begin
		nxt_irq = |(fl.flags & enable_ff);
	end

	// Interrupt flop keeps the output glitch free
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_ff <= 1'b0;
		end else begin
			irq_ff <= nxt_irq;
		end
	end

	assign irq_o = irq_ff;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	// A fresh request is answered on the next edge
	bus_ack_a: assert property (req && !ack_ff |=> ack_ff)
		else $error("ack not given one cycle after request");

	// Status write with no other activity leaves flags alone
	status_ro_a: assert property (
		wr_go && wb_adr_i == uevf_pkg::OFS_STATUS &&
		fl.hw_set == 14'h0 |=> $stable(fl.flags))
		else $error("status write altered a flag");

	// Interrupt follows masked flags one cycle later
	irq_follow_a: assert property (
		(fl.flags & enable_ff) != 14'h0 |=> irq_o)
		else $error("interrupt does not follow masked flags");

	// Pending but masked flags keep the line low
	irq_quiet_a: assert property (
		(fl.flags & enable_ff) == 14'h0 |=> !irq_o)
		else $error("interrupt raised without enabled flag");

	// Fully masked flags never raise the line
	irq_masked_a: assert property (
		enable_ff == 14'h0 |=> !irq_o)
		else $error("interrupt raised while all masked");

	// Frame flag present the cycle after the period ends
	frame_tick_a: assert property (
		frame_cnt_ff == FRAME_LAST |=> fl.flags[uevf_pkg::BIT_FRAME])
		else $error("frame flag missed its period");

	// Endpoint event lands on the shifted bit
	ep_map_a: assert property (ep_event_i != 8'h0 |=>
		((fl.flags[8:1] & $past(ep_event_i)) == $past(ep_event_i)))
		else $error("endpoint event on wrong bit");

	// Any bus change sets the bus flag
	bus_chg_a: assert property (
		bus_reset_i || suspend_chg_i || connect_chg_i |=>
		fl.flags[uevf_pkg::BIT_BUS])
		else $error("bus change flag not set");

	// Command slot flag high on the first cycle after reset
	cmd_free_a: assert property (
		$fell(rst_i) |-> fl.flags[uevf_pkg::BIT_CMD])
		else $error("command slot flag not high after reset");

	// Reply waiting flag follows the engine
	reply_a: assert property (reply_ready_i |=>
		fl.flags[uevf_pkg::BIT_REPLY])
		else $error("reply flag not set");

	// Count stepping onto zero sets the drained flag
	rx_drain_a: assert property (
		rx_remaining_i != 10'h0 ##1 rx_remaining_i == 10'h0 |=>
		fl.flags[uevf_pkg::BIT_RXD])
		else $error("drained flag not set");

	// Reaching the programmed length sets the filled flag
	tx_fill_a: assert property (
		$rose(tx_eq) |=> fl.flags[uevf_pkg::BIT_TXF])
		else $error("filled flag not set");

	// Finished command frees the slot flag
	cmd_done_a: assert property (cmd_done_i |=>
		fl.flags[uevf_pkg::BIT_CMD])
		else $error("slot free flag not set after command");

	// Ack is a single-cycle pulse
	ack_pulse_a: assert property (ack_ff |=> !ack_ff)
		else $error("ack held for more than one cycle");

	// Read data is zero outside the ack cycle
	dat_idle_a: assert property (!ack_ff |-> rdata_ff == 32'h0)
		else $error("read data not zero while idle");

	// Reserved status bits never read as one
	resv_zero_a: assert property (
		rdata_ff[31:14] == 18'h0)
		else $error("reserved bits read nonzero");

	// Reads of the write-only ports answer zero
	wo_read_a: assert property (
		req && !ack_ff && !wb_we_i &&
		(wb_adr_i == uevf_pkg::OFS_CLEAR ||
		wb_adr_i == uevf_pkg::OFS_SET) |=>
		rdata_ff == 32'h0)
		else $error("write-only port read nonzero");

	// Status read returns the flags of the request cycle
	status_rd_a: assert property (
		req && !ack_ff && !wb_we_i &&
		wb_adr_i == uevf_pkg::OFS_STATUS |=>
		rdata_ff[13:0] == $past(fl.flags))
		else $error("status read data wrong");

	// Full-word enable write stores the written bits
	enable_wr_a: assert property (
		wr_go && wb_adr_i == uevf_pkg::OFS_ENABLE && wb_sel_i == 4'hf
		|=> {18'h0, enable_ff} == ($past(wb_dat_i) & 32'h0000_3fff))
		else $error("enable write not stored");

	// Clear port drops every written bit when no event races it
	clr_port_a: assert property (
		wr_go && wb_adr_i == uevf_pkg::OFS_CLEAR && fl.hw_set == 14'h0
		|=> ({18'h0, fl.flags} & $past(wdata_m)) == 32'h0)
		else $error("clear port left a written bit set");

	// Main scenarios
	irq_seen_c: cover property ($rose(irq_o));
	clr_write_c: cover property (wr_go && wb_adr_i == uevf_pkg::OFS_CLEAR);
	set_write_c: cover property (wr_go && wb_adr_i == uevf_pkg::OFS_SET);
	frame_seen_c: cover property (frame_tick);

endmodule : uevf_top

/* File: tb/uevf_engine_model.sv */
// Far-side model: USB engine event sources feeding the flag block.
module uevf_engine_model (
	// Clock
	input wire logic clk_i,
	// Event pulses
	output logic [7:0] ep_event_o,
	output logic bus_reset_o,
	output logic suspend_chg_o,
	output logic connect_chg_o,
	output logic cmd_done_o,
	output logic reply_ready_o,
	// Packet byte counts
	output logic [9:0] rx_remaining_o,
	output logic [9:0] tx_written_o,
	output logic [9:0] transmit_length_o
);
	timeunit 1ns;
	timeprecision 1ps;

	// Pulse lanes: 7:0 endpoints, 10:8 bus changes, 11 command, 12 reply
	logic [12:0] pulse_ff = 13'h0000;

	assign ep_event_o = pulse_ff[7:0];
	assign bus_reset_o = pulse_ff[8];
	assign suspend_chg_o = pulse_ff[9];
	assign connect_chg_o = pulse_ff[10];
	assign cmd_done_o = pulse_ff[11];
	assign reply_ready_o = pulse_ff[12];

	// Counts start idle, length zero so no match fires
	initial begin
		rx_remaining_o = 10'h000;
		tx_written_o = 10'h000;
		transmit_length_o = 10'h000;
	end

	// One-cycle pulse, launched just after a rising edge like real logic
	task automatic pulse(input int idx);
		@(posedge clk_i);
		pulse_ff <= 13'h0001 << idx;
		@(posedge clk_i);
		pulse_ff <= 13'h0000;
	endtask : pulse

	// Counts move only right after an edge, as the engine's registers do
	task automatic counts(input logic [9:0] rx, input logic [9:0] tx,
		input logic [9:0] len);
		@(posedge clk_i);
		rx_remaining_o <= rx;
		tx_written_o <= tx;
		transmit_length_o <= len;
	endtask : counts

endmodule : uevf_engine_model

/* File: tb/tb_usb_device_event_flags.sv */
// Self-checking bench for the USB device event-flag block.
module tb_usb_device_event_flags;
	timeunit 1ns;
	timeprecision 1ps;

	// Short frame period keeps the tick test brief
	localparam int unsigned FRAMES = 20;
	// Flag mask without the frame bit, which ticks on its own
	localparam logic [31:0] NOFR = 32'h0000_3ffe;

	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic wb_cyc_i = 1'b0;
	logic wb_stb_i = 1'b0;
	logic wb_we_i = 1'b0;
	logic [7:0] wb_adr_i = 8'h00;
	logic [3:0] wb_sel_i = 4'h0;
	logic [31:0] wb_dat_i = 32'h0000_0000;
	logic [31:0] wb_dat_o;
	logic wb_ack_o;
	logic irq_o;
	logic [7:0] ep_ev;
	logic bus_rst, susp_chg, conn_chg, cmd_done, reply_rdy;
	logic [9:0] rx_rem, tx_wr, tx_len;
	logic [31:0] rd; // Last read data
	logic [3:0] sel_use = 4'hf; // Byte lanes for the next access
	int failures = 0;
	int checked = 0;

	// 100 MHz clock
	always #5 clk_i = ~clk_i;

	uevf_top #(.FRAME_CYCLES(FRAMES)) dut (
		.clk_i(clk_i), .rst_i(rst_i),
		.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
		.wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
		.ep_event_i(ep_ev), .bus_reset_i(bus_rst),
		.suspend_chg_i(susp_chg), .connect_chg_i(conn_chg),
		.cmd_done_i(cmd_done), .reply_ready_i(reply_rdy),
		.rx_remaining_i(rx_rem), .tx_written_i(tx_wr),
		.transmit_length_i(tx_len), .irq_o(irq_o));

	uevf_engine_model eng (
		.clk_i(clk_i), .ep_event_o(ep_ev), .bus_reset_o(bus_rst),
		.suspend_chg_o(susp_chg), .connect_chg_o(conn_chg),
		.cmd_done_o(cmd_done), .reply_ready_o(reply_rdy),
		.rx_remaining_o(rx_rem), .tx_written_o(tx_wr),
		.transmit_length_o(tx_len));

	// Compare and count
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			failures++;
			$display("BAD t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : chk

	// Classic Wishbone cycle; request held until ack is sampled high
	task automatic wb(input logic we, input logic [7:0] adr,
		input logic [31:0] dat);
		int n;
		n = 0;
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= adr;
		wb_dat_i <= dat;
		wb_sel_i <= sel_use;
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 50);
		if (n >= 50) failures++; // A missing ack is a mismatch
		rd = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i <= 1'b0;
	endtask : wb

	// Clear every flag; software keeps reserved bits zero
	task automatic clr_all();
		wb(1'b1, 8'h08, 32'h0000_3fff);
	endtask : clr_all

	// Reset values, read-only status, invalid reads of write-only ports
	task automatic t_reset_ro();
		wb(1'b0, 8'h00, 32'h0);
		chk(rd, 32'h0000_0400);
		wb(1'b0, 8'h04, 32'h0);
		chk(rd, 32'h0);
		chk({31'h0, irq_o}, 32'h0);
		wb(1'b1, 8'h00, 32'h0000_3bff);
		wb(1'b0, 8'h00, 32'h0);
		chk(rd & NOFR, 32'h0000_0400);
		chk({14'h0, rd[31:14]}, 32'h0);
		wb(1'b0, 8'h08, 32'h0); // Write-only ports read as zero here
		chk(rd, 32'h0);
		wb(1'b0, 8'h0c, 32'h0);
		chk(rd, 32'h0);
		clr_all();
		wb(1'b0, 8'h00, 32'h0);
		chk(rd & NOFR, 32'h0);
	endtask : t_reset_ro

	// Each endpoint, command and reply pulse lands on its own flag, bus changes on the shared bus flag, one at a time
	task automatic t_sources();
		logic [31:0] exp;
		for (int i = 0; i < 13; i++) begin
			exp = (i < 8) ? (32'h1 << (i + 1)) :
				(i < 11) ? 32'h0000_0200 :
				32'h1 << (i - 1);
			eng.pulse(i);
			wb(1'b0, 8'h00, 32'h0);
			chk(rd & NOFR, exp);
			clr_all();
		end
	endtask : t_sources

	// Receive count draining and transmit count meeting the length
	task automatic t_counts();
		eng.counts(10'd5, 10'd0, 10'd0);
		eng.counts(10'd0, 10'd0, 10'd0);
		wb(1'b0, 8'h00, 32'h0);
		chk(rd & NOFR, 32'h0000_1000);
		clr_all();
		eng.counts(10'd0, 10'd0, 10'd4);
		eng.counts(10'd0, 10'd4, 10'd4);
		wb(1'b0, 8'h00, 32'h0);
		chk(rd & NOFR, 32'h0000_2000);
		clr_all();
	endtask : t_counts

	// Set and clear ports act only on ones; mask gates the interrupt
	task automatic t_mask();
		wb(1'b1, 8'h0c, 32'h0000_3ffe);
		wb(1'b1, 8'h08, 32'h0000_00aa);
		wb(1'b0, 8'h00, 32'h0);
		chk(rd & NOFR, 32'h0000_3f54);
		clr_all();
		wb(1'b1, 8'h04, 32'h0000_0008);
		wb(1'b1, 8'h0c, 32'h0000_0010);
		repeat (3) @(posedge clk_i);
		chk({31'h0, irq_o}, 32'h0);
		wb(1'b0, 8'h00, 32'h0);
		chk(rd & NOFR, 32'h0000_0010);
		wb(1'b1, 8'h0c, 32'h0000_0008);
		repeat (3) @(posedge clk_i);
		chk({31'h0, irq_o}, 32'h1);
		wb(1'b1, 8'h08, 32'h0000_0008);
		repeat (3) @(posedge clk_i);
		chk({31'h0, irq_o}, 32'h0);
		wb(1'b0, 8'h04, 32'h0);
		chk(rd, 32'h0000_0008);
		sel_use = 4'h1; // Only the low lane may land
		wb(1'b1, 8'h04, 32'h0000_3fff);
		wb(1'b0, 8'h04, 32'h0);
		chk(rd, 32'h0000_00ff);
		clr_all();
		sel_use = 4'h2;
		wb(1'b1, 8'h0c, 32'h0000_3fff);
		sel_use = 4'hf;
		wb(1'b0, 8'h00, 32'h0);
		chk(rd & NOFR, 32'h0000_3f00);
		wb(1'b1, 8'h04, 32'h0);
		clr_all();
	endtask : t_mask

	// Event landing on the very edge a clear of that flag takes effect
	task automatic t_race();
		fork
			wb(1'b1, 8'h08, 32'h0000_0020);
			begin
				@(posedge clk_i);
				eng.pulse(4);
			end
		join
		wb(1'b0, 8'h00, 32'h0);
		chk(rd & NOFR, 32'h0000_0020);
		clr_all();
	endtask : t_race

	// Frame flag comes back within one frame period after a clear
	task automatic t_frame();
		wb(1'b1, 8'h08, 32'h0000_0001);
		repeat (FRAMES + 2) @(posedge clk_i);
		wb(1'b0, 8'h00, 32'h0);
		chk({31'h0, rd[0]}, 32'h1);
	endtask : t_frame

	// Verdict and end of run
	task automatic give_verdict();
		if (failures == 0 && checked > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : give_verdict

	// Main sequence
	initial begin
		repeat (6) @(posedge clk_i);
		rst_i <= 1'b0;
		t_reset_ro();
		t_sources();
		t_counts();
		t_mask();
		t_race();
		t_frame();
		give_verdict();
	end

	// Watchdog, far beyond the few hundred cycles the tests need
	initial begin
		#200us;
		failures++;
		give_verdict();
	end

endmodule : tb_usb_device_event_flags
